// ===== icd_cmd_cascade.sv
// Command decoder, response memory and cascade acknowledge logic
`timescale 1ns/1ps
`include "icd_defines.svh"

// Summary of operation
// - Command 100xxxxx copies its low five bits into mode bits 0-4.
// - Command 1010 loads command bits 3,2 into mode bits 6,5.
// - Its low two bits: 00 keep, 01 set, 10 clear master mask.
// - Command 1011 makes later data writes load the mask register.
// - Command 1100 makes later data writes load the auto-clear register.
// - Command 111 selects a response level and stores its byte count.
// - Byte count sets acknowledge readout length, not writes accepted.
// - Response bytes come out in the order they were written.
// - Low three command bits index bits 0 to 7 in binary.
// - Nibble 0001 clears request and mask, all or indexed bit.
// - Nibbles 0010/0011 clear/set mask bits, all or indexed.
// - Nibbles 0100/0101 clear/set request bits, all or indexed.
// - 0110 clears top in-service bit; 01110 all; 01111 indexed.
// - Acknowledge fall drives chain out low and holds off low.
// - After settling, wait while chain enable input is low.
// - Enabled with pending request: respond, release hold, send byte.
// - Enabled without pending request: raise chain enable out.
// - Shared response-active low releases every hold-off output.
// - While response-active is low only its driver answers acknowledges.
// - Selected device holds response-active until all bytes sent.
// - Group irq, hold-off and response-active are open-drain.
// - Zero command sets mask, clears request, service, auto, mode.
// - Each further acknowledge outputs the next stored byte.
// - First byte clears the request bit and sets in-service bit.
module icd_cmd_cascade (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Host write port, strobes active low, from pins
    input wire logic ctlWr_n,
    input wire logic dataWr_n,
    input wire logic [7:0] hostData,
    // Latched request events, same clock domain
    input wire logic [7:0] reqSet,
    // Cascade pins
    input wire logic ack_strobe_n,
    input wire logic chain_en_in,
    input wire logic resp_active_n_in,
    output logic chain_en_out,
    output icd_pkg::icd_od_t odOe,
    // Response data bus
    output logic [7:0] respData,
    output logic respDataOe,
    // Visible state
    output logic [7:0] modeOut,
    output logic [7:0] maskOut,
    output logic [7:0] reqOut,
    output logic [7:0] inServiceOut,
    output logic [7:0] autoClearOut
);
    import icd_pkg::*;

    function automatic logic [7:0] bitSel(input logic all, input logic [2:0] idx);
        bitSel = all ? 8'hFF : (8'h01 << idx);
    endfunction

    function automatic logic [2:0] topIdx(input logic [7:0] v);
        topIdx = 3'd0;
        for (int i = 7; i >= 0; i--)
            if (v[i])
                topIdx = i[2:0];
    endfunction

    logic ctlLvl, ctlFall, dataLvl, dataFall, ackLvl, ackFall, ackRise;
    logic enLvl, raLvl;
    logic [7:0] wrData_q, wrData_d;
    logic [7:0] hostMeta_q, hostSync_q;
    icd_write_t wr;

    icd_sync uCtl (.clk(clk), .rst_b(rst_b), .pinIn(ctlWr_n),
        .resetLevel(1'b1), .level(ctlLvl), .rise(), .fall(ctlFall));
    icd_sync uDat (.clk(clk), .rst_b(rst_b), .pinIn(dataWr_n),
        .resetLevel(1'b1), .level(dataLvl), .rise(), .fall(dataFall));
    icd_sync uAck (.clk(clk), .rst_b(rst_b), .pinIn(ack_strobe_n),
        .resetLevel(1'b1), .level(ackLvl), .rise(ackRise), .fall(ackFall));
    icd_sync uEn (.clk(clk), .rst_b(rst_b), .pinIn(chain_en_in),
        .resetLevel(1'b1), .level(enLvl), .rise(), .fall());
    icd_sync uRa (.clk(clk), .rst_b(rst_b), .pinIn(resp_active_n_in),
        .resetLevel(1'b1), .level(raLvl), .rise(), .fall());

    // Data takes two flops like the strobes, so both stay in step
    always_comb
    begin
        wrData_d = (!ctlLvl || !dataLvl) ? hostSync_q : wrData_q;
    end

    // Act once on the strobe's rising edge, i.e. a completed write
    logic ctlPrev_q, datPrev_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrData_q <= 8'h00;
            hostMeta_q <= 8'h00;
            hostSync_q <= 8'h00;
            ctlPrev_q <= 1'b1;
            datPrev_q <= 1'b1;
        end
        else
        begin
            wrData_q <= wrData_d;
            hostMeta_q <= hostData;
            hostSync_q <= hostMeta_q;
            ctlPrev_q <= ctlLvl;
            datPrev_q <= dataLvl;
        end
    end
    assign wr.wrCtl = ctlLvl & ~ctlPrev_q;
    assign wr.wrData = dataLvl & ~datPrev_q;
    assign wr.data = wrData_q;

    logic [7:0] mode_q, mode_d, mask_q, mask_d, req_q, req_d;
    logic [7:0] isr_q, isr_d, acr_q, acr_d;
    icd_target_t tgt_q, tgt_d;
    logic [2:0] lvl_q, lvl_d;
    logic [1:0] cnt_q [`ICD_NLEVEL];
    logic [1:0] cnt_d [`ICD_NLEVEL];
    logic [7:0] mem_q [`ICD_NLEVEL][`ICD_RESP_DEPTH];
    logic [1:0] wPtr_q [`ICD_NLEVEL];
    logic [1:0] wPtr_d [`ICD_NLEVEL];
    icd_state_t st_q, st_d;
    logic [2:0] sel_q, sel_d;
    logic [1:0] rPtr_q, rPtr_d;
    logic [2:0] settle_q, settle_d;
    logic holdOe_q, holdOe_d, raOe_q, raOe_d, eo_q, eo_d;
    logic [7:0] rdata_q, rdata_d;
    logic rdOe_q, rdOe_d;
    logic [7:0] pend;
    logic [7:0] cmd;
    logic all;

    assign pend = req_q & ~mask_q;
    assign cmd = wr.data;
    assign all = ~cmd[3];

    always_comb
    begin
        mode_d = mode_q;
        mask_d = mask_q;
        req_d = req_q | reqSet;
        isr_d = isr_q;
        acr_d = acr_q;
        tgt_d = tgt_q;
        lvl_d = lvl_q;
        for (int i = 0; i < `ICD_NLEVEL; i++)
        begin
            cnt_d[i] = cnt_q[i];
            wPtr_d[i] = wPtr_q[i];
        end
        if (wr.wrCtl)
        begin
            tgt_d = ICD_TGT_NONE;
            if (cmd == `ICD_CMD_RESET)
            begin
                mask_d = `ICD_MASK_RESET;
                req_d = reqSet;
                isr_d = 8'h00;
                acr_d = 8'h00;
                mode_d = 8'h00;
            end
            else if (cmd[7:5] == `ICD_OP_MODE_LOW)
                mode_d[4:0] = cmd[4:0];
            else if (cmd[7:5] == `ICD_OP_RESP_SEL)
            begin
                lvl_d = cmd[2:0];
                cnt_d[cmd[2:0]] = cmd[4:3];
                wPtr_d[cmd[2:0]] = 2'd0;
                tgt_d = ICD_TGT_RESP;
            end
            else
            begin
                unique case (cmd[7:4])
                    `ICD_NIB_CLR_REQMASK:
                    begin
                        req_d = (req_q & ~bitSel(all, cmd[2:0])) | reqSet;
                        mask_d = mask_q & ~bitSel(all, cmd[2:0]);
                    end
                    `ICD_NIB_CLR_MASK: mask_d = mask_q & ~bitSel(all, cmd[2:0]);
                    `ICD_NIB_SET_MASK: mask_d = mask_q | bitSel(all, cmd[2:0]);
                    `ICD_NIB_CLR_REQ: req_d = (req_q & ~bitSel(all, cmd[2:0])) | reqSet;
                    `ICD_NIB_SET_REQ: req_d = req_d | bitSel(all, cmd[2:0]);
                    `ICD_NIB_CLR_HIGH_IS:
                        if (|isr_q)
                            isr_d[topIdx(isr_q)] = 1'b0;
                    `ICD_NIB_CLR_IS: isr_d = isr_q & ~bitSel(all, cmd[2:0]);
                    `ICD_NIB_MODE_HIGH:
                    begin
                        mode_d[6:5] = cmd[3:2];
                        if (cmd[1:0] == `ICD_MM_SET)
                            mode_d[`ICD_MODE_MM] = 1'b1;
                        else if (cmd[1:0] == `ICD_MM_CLR)
                            mode_d[`ICD_MODE_MM] = 1'b0;
                    end
                    `ICD_NIB_SEL_MASK: tgt_d = ICD_TGT_MASK;
                    `ICD_NIB_SEL_AUTO: tgt_d = ICD_TGT_AUTO;
                    default: tgt_d = ICD_TGT_NONE;
                endcase
            end
        end
        else if (wr.wrData)
        begin
            unique case (tgt_q)
                ICD_TGT_MASK: mask_d = cmd;
                ICD_TGT_AUTO: acr_d = cmd;
                ICD_TGT_RESP: wPtr_d[lvl_q] = wPtr_q[lvl_q] + 2'd1;
                ICD_TGT_NONE: mask_d = mask_q;
            endcase
        end
        // Acknowledge takes the selected request into service
        // A new request on the same input in that cycle wins
        if (st_q == ICD_WAITEN && raLvl && enLvl && (|pend))
        begin
            req_d[topIdx(pend)] = reqSet[topIdx(pend)];
            isr_d[topIdx(pend)] = 1'b1;
        end
    end

    // Cascade state machine
    always_comb
    begin
        st_d = st_q;
        sel_d = sel_q;
        rPtr_d = rPtr_q;
        settle_d = settle_q;
        holdOe_d = holdOe_q;
        raOe_d = raOe_q;
        eo_d = eo_q;
        rdata_d = rdata_q;
        rdOe_d = rdOe_q;
        if (!raLvl && !raOe_q)
            holdOe_d = 1'b0;
        unique case (st_q)
            ICD_IDLE:
            begin
                rdOe_d = 1'b0;
                if (ackFall && raLvl)
                begin
                    eo_d = 1'b0;
                    holdOe_d = 1'b1;
                    settle_d = 3'(`ICD_SETTLE_CYC);
                    st_d = ICD_SETTLE;
                end
            end
            ICD_SETTLE:
            begin
                settle_d = settle_q - 3'd1;
                if (settle_q <= 3'd1)
                    st_d = ICD_WAITEN;
            end
            ICD_WAITEN:
            begin
                if (!raLvl)
                begin
                    holdOe_d = 1'b0;
                    st_d = ICD_IDLE;
                end
                else if (enLvl)
                begin
                    if (|pend)
                    begin
                        sel_d = topIdx(pend);
                        raOe_d = 1'b1;
                        holdOe_d = 1'b0;
                        rdata_d = mem_q[topIdx(pend)][0];
                        rdOe_d = 1'b1;
                        rPtr_d = 2'd1;
                        st_d = ICD_RESP;
                    end
                    else
                    begin
                        eo_d = 1'b1;
                        st_d = ICD_IDLE;
                    end
                end
            end
            ICD_RESP:
            begin
                if (ackRise)
                begin
                    rdOe_d = 1'b0;
                    // Pointer wraps after a four-byte answer: test equality
                    if (rPtr_q == 2'(cnt_q[sel_q] + 2'd1))
                    begin
                        raOe_d = 1'b0;
                        eo_d = 1'b1;
                        st_d = ICD_IDLE;
                    end
                end
                else if (ackFall)
                begin
                    rdata_d = mem_q[sel_q][rPtr_q];
                    rdOe_d = 1'b1;
                    rPtr_d = rPtr_q + 2'd1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_q <= 8'h00;
            mask_q <= `ICD_MASK_RESET;
            req_q <= 8'h00;
            isr_q <= 8'h00;
            acr_q <= 8'h00;
            tgt_q <= ICD_TGT_NONE;
            lvl_q <= 3'd0;
            for (int i = 0; i < `ICD_NLEVEL; i++)
            begin
                cnt_q[i] <= 2'd0;
                wPtr_q[i] <= 2'd0;
            end
            st_q <= ICD_IDLE;
            sel_q <= 3'd0;
            rPtr_q <= 2'd0;
            settle_q <= 3'd0;
            holdOe_q <= 1'b0;
            raOe_q <= 1'b0;
            eo_q <= 1'b1;
            rdata_q <= 8'h00;
            rdOe_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            mask_q <= mask_d;
            req_q <= req_d;
            isr_q <= isr_d;
            acr_q <= acr_d;
            tgt_q <= tgt_d;
            lvl_q <= lvl_d;
            cnt_q <= cnt_d;
            wPtr_q <= wPtr_d;
            st_q <= st_d;
            sel_q <= sel_d;
            rPtr_q <= rPtr_d;
            settle_q <= settle_d;
            holdOe_q <= holdOe_d;
            raOe_q <= raOe_d;
            eo_q <= eo_d;
            rdata_q <= rdata_d;
            rdOe_q <= rdOe_d;
        end
    end

    // Response memory has no reset: contents survive the reset command
    always_ff @(posedge clk)
    begin
        if (wr.wrData && tgt_q == ICD_TGT_RESP)
            mem_q[lvl_q][wPtr_q[lvl_q]] <= cmd;
    end

    logic gIrq_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            gIrq_q <= 1'b0;
        else
            gIrq_q <= (|pend) & ~mode_q[`ICD_MODE_MM];
    end

    assign chain_en_out = eo_q;
    assign odOe.holdOffOe = holdOe_q;
    assign odOe.respActiveOe = raOe_q;
    assign odOe.groupIrqOe = gIrq_q;
    assign respData = rdata_q;
    assign respDataOe = rdOe_q;
    assign modeOut = mode_q;
    assign maskOut = mask_q;
    assign reqOut = req_q;
    assign inServiceOut = isr_q;
    assign autoClearOut = acr_q;
endmodule // icd_cmd_cascade

// ===== icd_defines.svh
// Constants for the interrupt command decoder and cascade logic
`ifndef ICD_DEFINES_SVH
`define ICD_DEFINES_SVH
`define ICD_NLEVEL 8
`define ICD_RESP_DEPTH 4
`define ICD_MASK_RESET 8'hFF
`define ICD_CMD_RESET 8'h00
`define ICD_OP_MODE_LOW 3'b100
`define ICD_OP_RESP_SEL 3'b111
`define ICD_NIB_CLR_REQMASK 4'h1
`define ICD_NIB_CLR_MASK 4'h2
`define ICD_NIB_SET_MASK 4'h3
`define ICD_NIB_CLR_REQ 4'h4
`define ICD_NIB_SET_REQ 4'h5
`define ICD_NIB_CLR_HIGH_IS 4'h6
`define ICD_NIB_CLR_IS 4'h7
`define ICD_NIB_MODE_HIGH 4'hA
`define ICD_NIB_SEL_MASK 4'hB
`define ICD_NIB_SEL_AUTO 4'hC
`define ICD_MM_SET 2'b01
`define ICD_MM_CLR 2'b10
`define ICD_MODE_MM 7
`define ICD_SETTLE_NS 60
`define ICD_CLK_NS 20
`define ICD_SETTLE_CYC ((`ICD_SETTLE_NS + `ICD_CLK_NS - 1) / `ICD_CLK_NS)
`endif

// ===== icd_pkg.sv
// Types for the interrupt command decoder and cascade logic
package icd_pkg;
    typedef enum logic [1:0] {
        ICD_TGT_NONE = 2'b00,
        ICD_TGT_MASK = 2'b01,
        ICD_TGT_AUTO = 2'b10,
        ICD_TGT_RESP = 2'b11
    } icd_target_t;
    typedef enum logic [3:0] {
        ICD_IDLE = 4'b0001,
        ICD_SETTLE = 4'b0010,
        ICD_WAITEN = 4'b0100,
        ICD_RESP = 4'b1000
    } icd_state_t;
    typedef struct packed {
        logic wrCtl;
        logic wrData;
        logic [7:0] data;
    } icd_write_t;
    typedef struct packed {
        logic holdOffOe;
        logic respActiveOe;
        logic groupIrqOe;
    } icd_od_t;
endpackage

// ===== icd_sync.sv
// Two-flop synchroniser with edge pulses for pin inputs
`timescale 1ns/1ps
module icd_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Asynchronous level and its synchronised forms
    input wire logic pinIn,
    input wire logic resetLevel,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic prev_d;

    always_comb
    begin
        meta_d = pinIn;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d ^ resetLevel;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Inversion keeps reset constant while resetting to a chosen level
    assign level = sync_q ^ resetLevel;
    assign rise = (sync_q ^ resetLevel) & ~(prev_q ^ resetLevel);
    assign fall = ~(sync_q ^ resetLevel) & (prev_q ^ resetLevel);
endmodule // icd_sync

// ===== icd_cmd_cascade_props.sv
// Concurrent checks on the command decoder and cascade ports
`timescale 1ns/1ps
module icd_cmd_cascade_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Host and cascade inputs
    input wire logic ctlWr_n,
    input wire logic [7:0] hostData,
    input wire logic ack_strobe_n,
    input wire logic chain_en_in,
    input wire logic resp_active_n_in,
    // Design outputs
    input wire logic chain_en_out,
    input wire icd_pkg::icd_od_t odOe,
    input wire logic respDataOe,
    input wire logic [7:0] modeOut,
    input wire logic [7:0] maskOut,
    input wire logic [7:0] reqOut,
    input wire logic [7:0] inServiceOut,
    input wire logic [7:0] autoClearOut
);
    import icd_pkg::*;
    logic [7:0] lastCmd_d;
    logic [7:0] lastCmd_q;
    // Command byte as it stood while the strobe was low
    always_comb
    begin
        lastCmd_d = ctlWr_n ? lastCmd_q : hostData;
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            lastCmd_q <= 8'h00;
        else
            lastCmd_q <= lastCmd_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_ctlDone;
        !ctlWr_n ##1 ctlWr_n;
    endsequence
    sequence s_ackFall;
        $fell(ack_strobe_n) && resp_active_n_in;
    endsequence
    a_hold_on_ack: assert property (
        s_ackFall |-> ##[2:6] (odOe.holdOffOe && !chain_en_out))
        else $error("no hold-off after acknowledge");
    a_release_hold: assert property (
        $fell(resp_active_n_in) |-> ##[0:4] !odOe.holdOffOe)
        else $error("hold-off kept after response active");
    a_chain_wait: assert property (
        !chain_en_in [*3] ##0 !chain_en_out |=> !chain_en_out)
        else $error("chain out raised while chain in low");
    a_sel_release: assert property (
        odOe.respActiveOe |-> !odOe.holdOffOe && !chain_en_out)
        else $error("selected device holds off or passes chain");
    a_data_owner: assert property (
        respDataOe |-> odOe.respActiveOe)
        else $error("data driven without selection");
    a_foreign_quiet: assert property (
        !resp_active_n_in && !odOe.respActiveOe |=> !respDataOe)
        else $error("answered during foreign response");
    a_set_mask: assert property (
        s_ctlDone ##0 lastCmd_q == 8'h30 |-> ##[2:6] maskOut == 8'hFF)
        else $error("set all mask failed");
    a_reset_cmd: assert property (
        s_ctlDone ##0 lastCmd_q == 8'h00 |-> ##[2:6] (maskOut == 8'hFF
        && reqOut == 8'h00 && inServiceOut == 8'h00
        && autoClearOut == 8'h00 && modeOut == 8'h00))
        else $error("zero command state wrong");
    a_mode_low: assert property (
        s_ctlDone ##0 lastCmd_q[7:5] == 3'b100
        |-> ##[2:6] modeOut[4:0] == lastCmd_q[4:0])
        else $error("mode low field not loaded");
    a_mm_set: assert property (
        s_ctlDone ##0 (lastCmd_q[7:4] == 4'hA && lastCmd_q[1:0] == 2'b01)
        |-> ##[2:6] modeOut[7])
        else $error("master mask not set");
endmodule // icd_cmd_cascade_props

bind icd_cmd_cascade icd_cmd_cascade_props u_props (.clk, .rst_b,
    .ctlWr_n, .hostData, .ack_strobe_n, .chain_en_in, .resp_active_n_in,
    .chain_en_out, .odOe, .respDataOe, .modeOut, .maskOut, .reqOut,
    .inServiceOut, .autoClearOut);

// ===== icd_far_end.sv
// Wired lines and neighbouring cascade devices seen by the block
`timescale 1ns/1ps
module icd_far_end (
    // Bench controls for the neighbouring parties
    input wire logic upEn,
    input wire logic otherRip,
    // Enables from the device
    input wire icd_pkg::icd_od_t odOe,
    // Wires seen by the device and host
    output logic chain_en_in,
    output logic resp_active_n_in,
    output logic holdOffWire_n,
    output logic groupIrqWire_n
);
    import icd_pkg::*;
    // Upstream device passes the chain only when the bench lets it
    assign chain_en_in = upEn;
    // Pull-ups: each wire is low while any party pulls it
    assign resp_active_n_in = ~(odOe.respActiveOe | otherRip);
    assign holdOffWire_n = ~odOe.holdOffOe;
    assign groupIrqWire_n = ~odOe.groupIrqOe;
endmodule // icd_far_end

// ===== icd_cmd_cascade_tb.sv
// Self-checking bench for the command decoder and cascade logic
`timescale 1ns/1ps
module icd_cmd_cascade_tb;
    import icd_pkg::*;
    logic clk, rst_b, ctlWr_n, dataWr_n, ack_strobe_n, upEn, otherRip;
    logic chain_en_in, resp_active_n_in, chain_en_out, respDataOe;
    logic holdOffWire_n, groupIrqWire_n;
    logic [7:0] hostData, reqSet, respData, c;
    logic [7:0] modeOut, maskOut, reqOut, inServiceOut, autoClearOut;
    icd_od_t odOe;
    logic [31:0] rs;
    logic [7:0] fixed [6] = '{8'h30, 8'hA5, 8'hAB, 8'h9F, 8'hA2, 8'h00};
    int nFail = 0;
    int cmpCount = 0;
    int mMode, mMask, mReq, mIsr, mAcr, mTgt, mLvl, mPtr, n;
    int mMem [8][4];
    int nRead = ((8'hF2 >> 3) & 3) + 1;
    icd_cmd_cascade uut (.clk(clk), .rst_b(rst_b), .ctlWr_n(ctlWr_n),
        .dataWr_n(dataWr_n), .hostData(hostData), .reqSet(reqSet),
        .ack_strobe_n(ack_strobe_n), .chain_en_in(chain_en_in),
        .resp_active_n_in(resp_active_n_in), .chain_en_out(chain_en_out),
        .odOe(odOe), .respData(respData), .respDataOe(respDataOe),
        .modeOut(modeOut), .maskOut(maskOut), .reqOut(reqOut),
        .inServiceOut(inServiceOut), .autoClearOut(autoClearOut));
    icd_far_end far (.upEn(upEn), .otherRip(otherRip), .odOe(odOe),
        .chain_en_in(chain_en_in), .resp_active_n_in(resp_active_n_in),
        .holdOffWire_n(holdOffWire_n), .groupIrqWire_n(groupIrqWire_n));
    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input int exp);
        cmpCount++;
        if (got !== exp[7:0])
        begin
            nFail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp[7:0]);
        end
    endtask
    task automatic cmpAll;
        chk(modeOut, mMode);
        chk(maskOut, mMask);
        chk(reqOut, mReq);
        chk(inServiceOut, mIsr);
        chk(autoClearOut, mAcr);
    endtask
    task automatic apply(input bit ctl, input logic [7:0] v);
        int bm;
        bm = v[3] ? (1 << v[2:0]) : 8'hFF;
        if (!ctl)
            case (mTgt)
                1: mMask = v;
                2: mAcr = v;
                3:
                begin
                    mMem[mLvl][mPtr] = v;
                    mPtr = (mPtr + 1) % 4;
                end
                default: ;
            endcase
        else
        begin
            // Any command drops the data-port target
            mTgt = 0;
            if (v == 8'h00)
            begin
                mMask = 8'hFF;
                mReq = 0;
                mIsr = 0;
                mAcr = 0;
                mMode = 0;
            end
            else if (v[7:5] == 3'b100)
                mMode = (mMode & 8'hE0) | v[4:0];
            else if (v[7:5] == 3'b111)
            begin
                mTgt = 3;
                mLvl = v[2:0];
                mPtr = 0;
            end
            else
                case (v[7:4])
                    4'h1:
                    begin
                        mReq &= ~bm;
                        mMask &= ~bm;
                    end
                    4'h2: mMask &= ~bm;
                    4'h3: mMask |= bm;
                    4'h4: mReq &= ~bm;
                    4'h5: mReq |= bm;
                    4'h6: mIsr &= ~(mIsr & -mIsr);
                    4'h7: mIsr &= ~bm;
                    4'hB: mTgt = 1;
                    4'hC: mTgt = 2;
                    4'hA:
                    begin
                        mMode = (mMode & 8'h9F) | ((v & 8'h0C) << 3);
                        // Code 11 leaves the master mask alone
                        if (v[1:0] == 2'b01)
                            mMode |= 8'h80;
                        if (v[1:0] == 2'b10)
                            mMode &= 8'h7F;
                    end
                    default: ;
                endcase
        end
    endtask
    task automatic wr(input bit ctl, input logic [7:0] v);
        hostData = v;
        if (ctl)
            ctlWr_n = 0;
        else
            dataWr_n = 0;
        tick(4);
        ctlWr_n = 1;
        dataWr_n = 1;
        // Leaves room for the synchroniser before the compare
        tick(6);
        apply(ctl, v);
        cmpAll;
    endtask
    task automatic completeRun;
        $display("counts: fail %0d compare %0d", nFail, cmpCount);
        if (nFail == 0 && cmpCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #200_000;
        nFail++;
        completeRun;
    end
    initial
    begin
        {rst_b, hostData, reqSet, otherRip} = 0;
        {ctlWr_n, dataWr_n, ack_strobe_n, upEn} = 4'hF;
        rs = 32'h2718;
        {mMode, mReq, mIsr, mAcr, mTgt, mLvl, mPtr} = 0;
        mMask = 8'hFF;
        repeat (5) @(posedge clk);
        #1 rst_b = 1;
        tick(1);
        cmpAll;
        chk(chain_en_out, 1);
        for (int i = 0; i < 70; i++)
        begin
            rs = nxt(rs);
            c = i < 6 ? fixed[i] : rs[15:8];
            if (c != 0 && c[7:4] == 0)
                c[4] = 1;
            wr(i < 6 || rs[0], c);
        end
        wr(1, 8'h00);
        wr(1, 8'hF2);
        for (int j = 0; j < 4; j++)
        begin
            rs = nxt(rs);
            wr(0, rs[7:0]);
        end
        wr(1, 8'h20);
        wr(1, 8'hA2);
        reqSet = 8'h04;
        tick(1);
        reqSet = 8'h00;
        tick(3);
        mReq |= 4;
        cmpAll;
        chk(odOe.groupIrqOe, 1);
        wr(1, 8'hA1);
        chk(odOe.groupIrqOe, 0);
        wr(1, 8'hA2);
        // Another device is selected while this one waits on the chain
        upEn = 0;
        ack_strobe_n = 0;
        tick(8);
        chk(odOe.holdOffOe, 1);
        otherRip = 1;
        tick(6);
        chk(odOe.holdOffOe, 0);
        ack_strobe_n = 1;
        tick(4);
        ack_strobe_n = 0;
        tick(12);
        chk(respDataOe, 0);
        chk(odOe.holdOffOe, 0);
        ack_strobe_n = 1;
        tick(3);
        otherRip = 0;
        tick(6);
        ack_strobe_n = 0;
        tick(12);
        chk(respDataOe, 0);
        chk(chain_en_out, 0);
        chk(odOe.holdOffOe, 1);
        upEn = 1;
        for (int k = 0; k < nRead; k++)
        begin
            if (k > 0)
                ack_strobe_n = 0;
            n = 0;
            while (!(respDataOe === 1'b1 && holdOffWire_n === 1'b1) && n < 30)
            begin
                tick(1);
                n++;
            end
            chk(respData, mMem[2][k]);
            chk(odOe.holdOffOe, 0);
            ack_strobe_n = 1;
            tick(8);
            chk(odOe.respActiveOe, k < nRead - 1);
            if (k == 0)
            begin
                mReq &= ~4;
                mIsr |= 4;
                cmpAll;
            end
        end
        chk(chain_en_out, 1);
        ack_strobe_n = 0;
        tick(5);
        chk(chain_en_out, 0);
        tick(7);
        chk(chain_en_out, 1);
        chk(respDataOe, 0);
        ack_strobe_n = 1;
        tick(6);
        wr(1, 8'h60);
        completeRun;
    end
endmodule // icd_cmd_cascade_tb
